/* rtl/sfwp.sv */
// Serial flash command acceptance, write protection and busy control
`timescale 1ns/10ps

module sfwp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_in, // Clock
	input wire logic rst_n_in, // Synchronous reset, active low
	input wire logic in_valid_in, // Write request
	input wire logic [WIDTH-1:0] in_data_in, // Write data
	output logic in_ready_out, // Space available
	output logic out_valid_out, // Data available
	output logic [WIDTH-1:0] out_data_out, // Read data
	input wire logic out_ready_in // Consumer takes the word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire push = in_valid_in & in_ready_out;
	wire pop = out_valid_out & out_ready_in;
	assign in_ready_out = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) | (wr_ptr[AW] == rd_ptr[AW]);
	assign out_valid_out = wr_ptr != rd_ptr;
	assign out_data_out = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop) rd_ptr <= rd_ptr + 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (push) mem[wr_ptr[AW-1:0]] <= in_data_in;
	end
endmodule : sfwp_fifo

module sfwp #(
	parameter logic [31:0] PROGRAM_CYCLES = sfwp_pkg::PROGRAM_CYCLES,
	parameter logic [31:0] SMALL_CLEAR_CYCLES = sfwp_pkg::SMALL_CLEAR_CYCLES,
	parameter logic [31:0] BLOCK_CLEAR_CYCLES = sfwp_pkg::BLOCK_CLEAR_CYCLES,
	parameter logic [31:0] FULL_CLEAR_CYCLES = sfwp_pkg::FULL_CLEAR_CYCLES,
	parameter logic [31:0] STATUS_WRITE_CYCLES = sfwp_pkg::STATUS_WRITE_CYCLES,
	parameter logic [31:0] POWERUP_CYCLES = sfwp_pkg::POWERUP_CYCLES,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic CLK_IN, // System clock
	input wire logic RST_N_IN, // Synchronous reset, active low
	input wire logic SCK_IN, // Serial clock pin
	input wire logic CS_N_IN, // Chip select pin, active low
	input wire logic SERIAL_IN_LINE_IN, // Serial data in
	input wire logic SERIAL_OUT_LINE_IN, // Output line read back for dual program
	output logic SERIAL_OUT_LINE_OUT, // Serial data out
	output logic SERIAL_OUT_LINE_OE_OUT, // Output enable of serial data out
	input wire logic WP_N_IN, // Write protect pin, active low
	input wire logic VCC_OK_IN, // Supply within operating range
	output logic OP_START_OUT, // Accepted operation pulse
	output logic OP_REJECT_OUT, // Refused modifying command pulse
	output sfwp_pkg::sfwp_op_type OP_KIND_OUT, // Kind of accepted operation
	output logic [23:0] OP_ADDR_OUT, // Address of accepted operation
	output logic [8:0] OP_COUNT_OUT, // Data bytes of accepted program
	output logic [7:0] PROG_DATA_OUT, // Program data byte
	output logic PROG_VALID_OUT, // Program data valid
	input wire logic PROG_READY_IN, // Program data taken
	output logic [7:0] STATUS_OUT, // Status register
	output logic DEEP_OUT, // Deep power-down active
	output logic STANDBY_OUT // Standby power mode
);
	localparam int SECTORS = 1 << sfwp_pkg::SECTOR_BITS;

	logic [2:0] sck_s;
	logic [2:0] cs_s;
	logic [1:0] si_s;
	logic [1:0] so_s;
	logic [1:0] wp_s;
	logic [1:0] vcc_s;
	logic [15:0] clk_cnt;
	logic [7:0] rx;
	logic [3:0] rx_n;
	logic [9:0] byte_n;
	logic [8:0] data_n;
	logic [7:0] cmd;
	logic [7:0] arg;
	logic [23:0] addr;
	logic overrun;
	sfwp_pkg::sfwp_mode_type mode;
	logic [31:0] busy_cnt;
	logic [31:0] pu_cnt;
	logic write_enable_latch_flag;
	logic status_write_disable_bit;
	logic top_bottom_bit;
	logic [2:0] protect_size;
	logic [SECTORS-1:0] lock_wr;
	logic [SECTORS-1:0] lock_dn;
	logic so_oe;
	logic fifo_ready;
	sfwp_pkg::sfwp_op_type go_kind;
	logic go_ok;
	logic [31:0] go_cycles;

	// Pins cross into the system clock through two flops
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			sck_s <= 3'h0;
			cs_s <= 3'h7;
			si_s <= 2'h0;
			so_s <= 2'h0;
			wp_s <= 2'h0;
			vcc_s <= 2'h0;
		end else begin
			sck_s <= {sck_s[1:0], SCK_IN};
			cs_s <= {cs_s[1:0], CS_N_IN};
			si_s <= {si_s[0], SERIAL_IN_LINE_IN};
			so_s <= {so_s[0], SERIAL_OUT_LINE_IN};
			wp_s <= {wp_s[0], WP_N_IN};
			vcc_s <= {vcc_s[0], VCC_OK_IN};
		end
	end

	// Only edges matter, so either idle level of the serial clock works
	wire sel = ~cs_s[1];
	wire sck_rise = sck_s[1] & ~sck_s[2];
	wire sck_fall = ~sck_s[1] & sck_s[2];
	wire cs_fall = ~cs_s[1] & cs_s[2];
	wire cs_rise = cs_s[1] & ~cs_s[2];

	wire dual = (cmd == sfwp_pkg::CMD_DUAL_PROG) & (byte_n >= sfwp_pkg::HDR_BYTES);
	wire [3:0] next_rx_n = rx_n + (dual ? 4'h2 : 4'h1);
	wire [7:0] next_rx = dual ? {rx[5:0], so_s[1], si_s[1]} : {rx[6:0], si_s[1]};
	wire byte_done = sck_rise & sel & (next_rx_n == sfwp_pkg::BYTE_BITS);
	wire prog_cmd = (cmd == sfwp_pkg::CMD_PAGE_PROG) | (cmd == sfwp_pkg::CMD_DUAL_PROG)
		| (cmd == sfwp_pkg::CMD_OTP_PROG);
	wire data_byte = byte_done & prog_cmd & (byte_n >= sfwp_pkg::HDR_BYTES);
	wire [9:0] page_end = {2'h0, addr[sfwp_pkg::PAGE_HI:0]} + {1'b0, data_n};
	wire room = page_end < sfwp_pkg::PAGE_BYTES;
	wire push = data_byte & room & fifo_ready & (mode == sfwp_pkg::MODE_READY);

	// Serial receive on rising serial clock edges
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN || cs_fall) begin
			clk_cnt <= 16'h0;
			rx_n <= 4'h0;
			byte_n <= 10'h0;
			data_n <= 9'h0;
			overrun <= 1'b0;
			cmd <= 8'h0;
		end else if (sck_rise & sel) begin
			if (clk_cnt != 16'hffff) clk_cnt <= clk_cnt + 16'h1;
			rx_n <= byte_done ? 4'h0 : next_rx_n;
			if (byte_done & (byte_n != 10'h3ff)) byte_n <= byte_n + 10'h1;
			if (byte_done & (byte_n == 10'h0)) cmd <= next_rx;
			if (push) data_n <= data_n + 9'h1;
			// Bytes beyond the page or a full buffer spoil the sequence
			if (data_byte & ~push) overrun <= 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			rx <= 8'h0;
			arg <= 8'h0;
			addr <= 24'h0;
		end else if (sck_rise & sel) begin
			rx <= next_rx;
			if (byte_done) arg <= next_rx;
			if (byte_done & (byte_n != 10'h0) & (byte_n < sfwp_pkg::HDR_BYTES)) begin
				addr <= {addr[15:0], next_rx};
			end
		end
	end

	// Protection of the addressed sector
	wire [sfwp_pkg::SECTOR_BITS-1:0] sec = addr[sfwp_pkg::SEC_HI:sfwp_pkg::SEC_LO];
	wire [3:0] size_mask = 4'(4'hf << (protect_size - 3'h1));
	wire size_hit = top_bottom_bit ? ((sec & size_mask) == 4'h0)
		: ((sec & size_mask) == size_mask);
	wire size_prot = (protect_size >= sfwp_pkg::BP_ALL)
		| ((protect_size != sfwp_pkg::BP_NONE) & size_hit);
	wire prot = size_prot | lock_wr[sec];

	wire whole = clk_cnt[2:0] == 3'h0;
	wire inhibit = (pu_cnt != 32'h0) | ~vcc_s[1];
	wire ready = mode == sfwp_pkg::MODE_READY;
	wire mod_ok = whole & write_enable_latch_flag & ready & ~inhibit;
	wire len8 = cs_rise & (clk_cnt == sfwp_pkg::LEN_CMD);
	wire guard_go = cs_rise & (cmd == sfwp_pkg::CMD_SECTOR_GUARD_WRITE)
		& (clk_cnt == sfwp_pkg::LEN_GUARD) & write_enable_latch_flag & ready & ~inhibit;

	always_comb begin
		go_kind = sfwp_pkg::OPK_NONE;
		go_ok = 1'b0;
		unique case (cmd)
			sfwp_pkg::CMD_PAGE_PROG, sfwp_pkg::CMD_DUAL_PROG: begin
				go_kind = sfwp_pkg::OPK_PROG;
				go_ok = (clk_cnt >= sfwp_pkg::LEN_PROG_MIN) & ~overrun & ~prot
					& (data_n != 9'h0);
			end
			sfwp_pkg::CMD_OTP_PROG: begin
				go_kind = sfwp_pkg::OPK_OTP;
				go_ok = (clk_cnt >= sfwp_pkg::LEN_PROG_MIN) & ~overrun & (data_n != 9'h0);
			end
			sfwp_pkg::CMD_SMALL_CLEAR: begin
				go_kind = sfwp_pkg::OPK_SMALL;
				go_ok = (clk_cnt == sfwp_pkg::LEN_ADDR) & ~prot;
			end
			sfwp_pkg::CMD_BLOCK_CLEAR: begin
				go_kind = sfwp_pkg::OPK_BLOCK;
				go_ok = (clk_cnt == sfwp_pkg::LEN_ADDR) & ~prot;
			end
			sfwp_pkg::CMD_FULL_CLEAR: begin
				go_kind = sfwp_pkg::OPK_FULL;
				go_ok = (clk_cnt == sfwp_pkg::LEN_CMD) & (protect_size == sfwp_pkg::BP_NONE)
					& (lock_wr == '0);
			end
			sfwp_pkg::CMD_WRITE_STATUS: begin
				go_kind = sfwp_pkg::OPK_STATUS;
				go_ok = (clk_cnt == sfwp_pkg::LEN_STATUS) & wp_s[1];
			end
			default: begin
			end
		endcase
	end

	wire go = cs_rise & mod_ok & go_ok;
	wire refuse = cs_rise & (go_kind != sfwp_pkg::OPK_NONE) & ~go;

	// Each erase kind and the status write run for their own time
	always_comb begin
		unique case (go_kind)
			sfwp_pkg::OPK_SMALL: go_cycles = SMALL_CLEAR_CYCLES;
			sfwp_pkg::OPK_BLOCK: go_cycles = BLOCK_CLEAR_CYCLES;
			sfwp_pkg::OPK_FULL: go_cycles = FULL_CLEAR_CYCLES;
			sfwp_pkg::OPK_STATUS: go_cycles = STATUS_WRITE_CYCLES;
			default: go_cycles = PROGRAM_CYCLES;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			mode <= sfwp_pkg::MODE_READY;
			busy_cnt <= 32'h0;
		end else begin
			unique case (mode)
				sfwp_pkg::MODE_READY: begin
					if (go) begin
						mode <= sfwp_pkg::MODE_BUSY;
						busy_cnt <= go_cycles;
					end else if (len8 & (cmd == sfwp_pkg::CMD_SLEEP)) begin
						mode <= sfwp_pkg::MODE_DEEP;
					end
				end
				sfwp_pkg::MODE_BUSY: begin
					busy_cnt <= busy_cnt - 32'h1;
					if (busy_cnt <= 32'h1) mode <= sfwp_pkg::MODE_READY;
				end
				sfwp_pkg::MODE_DEEP: begin
					if (len8 & (cmd == sfwp_pkg::CMD_WAKE)) mode <= sfwp_pkg::MODE_READY;
				end
			endcase
		end
	end

	// Power-up timer restarts whenever the supply drops out
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) pu_cnt <= POWERUP_CYCLES;
		else if (~vcc_s[1]) pu_cnt <= POWERUP_CYCLES;
		else if (pu_cnt != 32'h0) pu_cnt <= pu_cnt - 32'h1;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			write_enable_latch_flag <= 1'b0;
			status_write_disable_bit <= 1'b0;
			top_bottom_bit <= 1'b0;
			protect_size <= sfwp_pkg::BP_NONE;
		end else begin
			if (go | guard_go | (len8 & (cmd == sfwp_pkg::CMD_DISARM_WRITE))) begin
				write_enable_latch_flag <= 1'b0;
			end else if (len8 & (cmd == sfwp_pkg::CMD_ARM_WRITE) & ready) begin
				write_enable_latch_flag <= 1'b1;
			end
			if (go & (go_kind == sfwp_pkg::OPK_STATUS)) begin
				status_write_disable_bit <= arg[sfwp_pkg::SR_SWD];
				top_bottom_bit <= arg[sfwp_pkg::SR_TB];
				protect_size <= arg[sfwp_pkg::SR_SIZE_HI:sfwp_pkg::SR_SIZE_LO];
			end
		end
	end

	for (genvar i = 0; i < SECTORS; i++) begin : g_guard
		always_ff @(posedge CLK_IN) begin
			if (!RST_N_IN) begin
				lock_wr[i] <= 1'b0;
				lock_dn[i] <= 1'b0;
			end else if (guard_go & (sec == (sfwp_pkg::SECTOR_BITS)'(i)) & ~lock_dn[i]) begin
				lock_wr[i] <= arg[sfwp_pkg::LK_WRITE];
				lock_dn[i] <= arg[sfwp_pkg::LK_DOWN];
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			OP_START_OUT <= 1'b0;
			OP_REJECT_OUT <= 1'b0;
			OP_KIND_OUT <= sfwp_pkg::OPK_NONE;
			OP_ADDR_OUT <= 24'h0;
			OP_COUNT_OUT <= 9'h0;
		end else begin
			OP_START_OUT <= go;
			OP_REJECT_OUT <= refuse;
			if (go) begin
				OP_KIND_OUT <= go_kind;
				OP_ADDR_OUT <= addr;
				OP_COUNT_OUT <= data_n;
			end
		end
	end

	// Serial transmit from falling serial clock edges
	wire rd_status = (cmd == sfwp_pkg::CMD_READ_STATUS) & (clk_cnt >= sfwp_pkg::LEN_CMD);
	wire rd_guard = (cmd == sfwp_pkg::CMD_SECTOR_GUARD_READ) & (clk_cnt >= sfwp_pkg::LEN_ADDR);
	wire out_active = sel & (mode != sfwp_pkg::MODE_DEEP) & (rd_status | rd_guard);
	wire [7:0] out_byte = rd_guard ? {6'h0, lock_dn[sec], lock_wr[sec]} : STATUS_OUT;

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			SERIAL_OUT_LINE_OUT <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			so_oe <= out_active;
			if (sck_fall & out_active) SERIAL_OUT_LINE_OUT <= out_byte[~clk_cnt[2:0]];
		end
	end

	assign SERIAL_OUT_LINE_OE_OUT = so_oe & sel;
	assign STATUS_OUT = {status_write_disable_bit, 1'b0, top_bottom_bit, protect_size,
		write_enable_latch_flag, mode == sfwp_pkg::MODE_BUSY};
	assign DEEP_OUT = mode == sfwp_pkg::MODE_DEEP;
	assign STANDBY_OUT = cs_s[1] & ready;

	sfwp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.in_valid_in(push),
		.in_data_in(next_rx),
		.in_ready_out(fifo_ready),
		.out_valid_out(PROG_VALID_OUT),
		.out_data_out(PROG_DATA_OUT),
		.out_ready_in(PROG_READY_IN)
	);

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	sequence small_go_s;
		OP_START_OUT && OP_KIND_OUT == sfwp_pkg::OPK_SMALL;
	endsequence
	sequence busy_hold_s;
		STATUS_OUT[0] [*8];
	endsequence

	oe_when_sel_a: assert property (SERIAL_OUT_LINE_OE_OUT |-> !cs_s[1])
		else $error("output driven while deselected");
	capture_rise_a: assert property (sck_rise && sel && !dual |=> rx[0] == $past(si_s[1]))
		else $error("input bit not captured on rising edge");
	start_armed_a: assert property (OP_START_OUT |-> $past(write_enable_latch_flag))
		else $error("operation started without write enable");
	whole_bytes_a: assert property (OP_START_OUT |-> $past(clk_cnt[2:0]) == 3'h0)
		else $error("operation started on partial byte");
	deep_ignore_a: assert property ($past(mode) == sfwp_pkg::MODE_DEEP |-> !OP_START_OUT)
		else $error("operation started in deep power-down");
	start_busy_a: assert property (OP_START_OUT |-> STATUS_OUT[0] && !STANDBY_OUT)
		else $error("busy flag not set at start");
	clear_busy_a: assert property (small_go_s |-> busy_hold_s)
		else $error("erase cycle ended too early");
	bulk_size_a: assert property (OP_START_OUT && OP_KIND_OUT == sfwp_pkg::OPK_FULL
		|-> $past(protect_size) == sfwp_pkg::BP_NONE)
		else $error("bulk erase with size bits set");
	region_guard_a: assert property (OP_START_OUT && OP_KIND_OUT inside {sfwp_pkg::OPK_PROG,
		sfwp_pkg::OPK_SMALL, sfwp_pkg::OPK_BLOCK} |-> !$past(prot))
		else $error("protected sector modified");
	lock_down_a: assert property (((lock_wr ^ $past(lock_wr)) & $past(lock_dn)) == '0)
		else $error("locked-down guard bit changed");
	powerup_block_a: assert property ($past(pu_cnt) != 32'h0 |-> !OP_START_OUT)
		else $error("operation during power-up inhibit");
	status_frozen_a: assert property (OP_START_OUT && OP_KIND_OUT == sfwp_pkg::OPK_STATUS
		|-> $past(wp_s[1]))
		else $error("status written while write protect asserted");
	reject_excl_a: assert property (OP_REJECT_OUT |-> !OP_START_OUT)
		else $error("refused command still started");
endmodule : sfwp

/* inc/sfwp_pkg.sv */
// Constants and types for the serial flash write-protect control block
package sfwp_pkg;
	localparam longint unsigned CLK_MHZ = 100;
	localparam longint unsigned PROGRAM_CYCLE_TIME_US = 5000;
	localparam longint unsigned SMALL_BLOCK_CLEAR_TIME_US = 300000;
	localparam longint unsigned BLOCK_CLEAR_TIME_US = 3000000;
	localparam longint unsigned FULL_CLEAR_TIME_US = 20000000;
	localparam longint unsigned STATUS_WRITE_TIME_US = 15000;
	localparam longint unsigned POWERUP_WRITE_INHIBIT_TIME_US = 10000;
	localparam logic [31:0] PROGRAM_CYCLES = 32'(PROGRAM_CYCLE_TIME_US * CLK_MHZ);
	localparam logic [31:0] SMALL_CLEAR_CYCLES = 32'(SMALL_BLOCK_CLEAR_TIME_US * CLK_MHZ);
	localparam logic [31:0] BLOCK_CLEAR_CYCLES = 32'(BLOCK_CLEAR_TIME_US * CLK_MHZ);
	localparam logic [31:0] FULL_CLEAR_CYCLES = 32'(FULL_CLEAR_TIME_US * CLK_MHZ);
	localparam logic [31:0] STATUS_WRITE_CYCLES = 32'(STATUS_WRITE_TIME_US * CLK_MHZ);
	localparam logic [31:0] POWERUP_CYCLES = 32'(POWERUP_WRITE_INHIBIT_TIME_US * CLK_MHZ);

	localparam logic [7:0] CMD_ARM_WRITE = 8'h06;
	localparam logic [7:0] CMD_DISARM_WRITE = 8'h04;
	localparam logic [7:0] CMD_READ_STATUS = 8'h05;
	localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
	localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
	localparam logic [7:0] CMD_DUAL_PROG = 8'ha2;
	localparam logic [7:0] CMD_OTP_PROG = 8'h42;
	localparam logic [7:0] CMD_SMALL_CLEAR = 8'h20;
	localparam logic [7:0] CMD_BLOCK_CLEAR = 8'hd8;
	localparam logic [7:0] CMD_FULL_CLEAR = 8'hc7;
	localparam logic [7:0] CMD_SLEEP = 8'hb9;
	localparam logic [7:0] CMD_WAKE = 8'hab;
	localparam logic [7:0] CMD_SECTOR_GUARD_READ = 8'he8;
	localparam logic [7:0] CMD_SECTOR_GUARD_WRITE = 8'he5;

	localparam logic [15:0] LEN_CMD = 16'h0008;
	localparam logic [15:0] LEN_STATUS = 16'h0010;
	localparam logic [15:0] LEN_ADDR = 16'h0020;
	localparam logic [15:0] LEN_GUARD = 16'h0028;
	localparam logic [15:0] LEN_PROG_MIN = 16'h0028;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [9:0] HDR_BYTES = 10'h004;
	localparam logic [9:0] PAGE_BYTES = 10'h100;

	localparam int SR_SIZE_LO = 2;
	localparam int SR_SIZE_HI = 4;
	localparam int SR_TB = 5;
	localparam int SR_SWD = 7;
	localparam int LK_WRITE = 0;
	localparam int LK_DOWN = 1;
	localparam int SEC_LO = 16;
	localparam int SEC_HI = 19;
	localparam int PAGE_HI = 7;
	localparam int SECTOR_BITS = 4;
	localparam logic [2:0] BP_NONE = 3'h0;
	localparam logic [2:0] BP_ALL = 3'h5;

	typedef enum logic [1:0] {MODE_READY, MODE_BUSY, MODE_DEEP} sfwp_mode_type;
	typedef enum logic [2:0] {
		OPK_NONE, OPK_PROG, OPK_OTP, OPK_SMALL, OPK_BLOCK, OPK_FULL, OPK_STATUS
	} sfwp_op_type;
endpackage : sfwp_pkg

/* tb/sfwp_host.sv */
// Host serial master model driving select, clock and data of the flash block
`timescale 1ns/10ps

module sfwp_host (
	input wire logic clk_in, // System clock
	input wire logic so_in, // Resolved serial out wire
	output logic sck_out, // Serial clock
	output logic cs_n_out, // Chip select, active low
	output logic si_out, // Serial data in
	output logic hi_out, // Upper dual bit onto the out wire
	output logic hi_en_out // Host drives the out wire
);
	logic cpol = 1'b0;
	logic [63:0] rx = 64'h0;

	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
		hi_out = 1'b0;
		hi_en_out = 1'b0;
	end

	// MSB first over n clocks; from clock dual_at on, two bits per clock
	task frame(input logic [63:0] d, input int n, input int dual_at);
		int i;
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		for (i = 0; i < n; i++) begin
			@(posedge clk_in);
			sck_out <= 1'b0;
			if (i >= dual_at) begin
				hi_en_out <= 1'b1;
				hi_out <= d[63];
				si_out <= d[62];
				d = d << 2;
			end else begin
				si_out <= d[63];
				d = d << 1;
			end
			repeat (8) @(posedge clk_in);
			sck_out <= 1'b1;
			repeat (8) @(posedge clk_in);
			rx = {rx[62:0], so_in};
		end
		sck_out <= cpol;
		repeat (8) @(posedge clk_in);
		cs_n_out <= 1'b1;
		si_out <= ~si_out;
		hi_en_out <= 1'b0;
	endtask : frame
endmodule : sfwp_host

/* tb/tb_sfwp.sv */
// Self-checking bench for the serial flash write-protect block
`timescale 1ns/10ps

module tb_sfwp;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic vcc_ok = 1'b0;
	logic ready = 1'b1;
	logic flt = 1'b0;
	logic sck, cs_n, si, hi, hi_en, so_out, so_oe, so_wire;
	logic op_start, op_reject, deep, standby, pvalid;
	sfwp_pkg::sfwp_op_type op_kind;
	logic [23:0] op_addr;
	logic [8:0] op_count;
	logic [7:0] pdata, status;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	int n_start = 0;
	int n_rej = 0;
	int k;
	// Shortened internal cycle lengths keep the run brief
	localparam logic [31:0] T_SHORT = 32'h14;
	localparam logic [31:0] T_LONG = 32'h1e;

	// Unowned out wire wanders so a stale value never looks right
	assign so_wire = so_oe ? so_out : (hi_en ? hi : flt);

	initial forever #5 clk = ~clk;

	sfwp_host u_host (.clk_in(clk), .so_in(so_wire), .sck_out(sck), .cs_n_out(cs_n),
		.si_out(si), .hi_out(hi), .hi_en_out(hi_en));

	sfwp #(.PROGRAM_CYCLES(T_SHORT), .SMALL_CLEAR_CYCLES(T_LONG), .BLOCK_CLEAR_CYCLES(T_LONG),
		.FULL_CLEAR_CYCLES(T_LONG), .STATUS_WRITE_CYCLES(T_SHORT), .POWERUP_CYCLES(T_SHORT))
		u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .SCK_IN(sck), .CS_N_IN(cs_n),
		.SERIAL_IN_LINE_IN(si), .SERIAL_OUT_LINE_IN(so_wire), .SERIAL_OUT_LINE_OUT(so_out),
		.SERIAL_OUT_LINE_OE_OUT(so_oe), .WP_N_IN(wp_n), .VCC_OK_IN(vcc_ok),
		.OP_START_OUT(op_start), .OP_REJECT_OUT(op_reject), .OP_KIND_OUT(op_kind),
		.OP_ADDR_OUT(op_addr), .OP_COUNT_OUT(op_count), .PROG_DATA_OUT(pdata),
		.PROG_VALID_OUT(pvalid), .PROG_READY_IN(ready), .STATUS_OUT(status),
		.DEEP_OUT(deep), .STANDBY_OUT(standby));

	task report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		flt <= ~flt;
		cyc++;
		if (op_start === 1'b1)
			n_start++;
		if (op_reject === 1'b1)
			n_rej++;
		if (cyc == 60000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	function automatic logic [63:0] hdr(input logic [7:0] c, input logic [23:0] a,
		input logic [31:0] t);
		return {c, a, t};
	endfunction : hdr

	// Result codes: 0 nothing, 1 accepted, 2 refused, 3 only no start
	task op(input logic [63:0] d, input int n, input int dual_at, input int exp);
		int s0;
		int r0;
		s0 = n_start;
		r0 = n_rej;
		u_host.frame(d, n, dual_at);
		repeat (12) @(posedge clk);
		#1;
		chk("start", 32'(exp == 1), 32'(n_start - s0));
		if (exp < 3)
			chk("reject", 32'(exp == 2), 32'(n_rej - r0));
		chk("oe idle", 32'h0, 32'(so_oe));
	endtask : op

	task arm();
		op(hdr(sfwp_pkg::CMD_ARM_WRITE, 24'h0, 32'h0), 8, 99, 0);
	endtask : arm

	task rd_status(input logic [7:0] exp);
		u_host.frame(hdr(sfwp_pkg::CMD_READ_STATUS, 24'h0, 32'h0), 16, 99);
		#1;
		chk("status pin", 32'(exp), 32'(u_host.rx[7:0]));
		chk("status", 32'(exp), 32'(status));
	endtask : rd_status

	task rd_guard(input logic [7:0] exp);
		u_host.frame(hdr(sfwp_pkg::CMD_SECTOR_GUARD_READ, 24'h050000, 32'h0), 40, 99);
		#1;
		chk("guard pin", 32'(exp), 32'(u_host.rx[7:0]));
	endtask : rd_guard

	task pop(input logic [7:0] exp);
		chk("fifo valid", 32'h1, 32'(pvalid));
		chk("fifo data", 32'(exp), 32'(pdata));
		@(posedge clk) ready <= 1'b1;
		@(posedge clk) ready <= 1'b0;
		#1;
	endtask : pop

	task wait_idle();
		for (k = 0; k < 100 && status[0] !== 1'b0; k++)
			@(posedge clk);
		#1;
		chk("busy", 32'h0, 32'(status[0]));
	endtask : wait_idle

	localparam logic [7:0] ERASES [3] = '{sfwp_pkg::CMD_SMALL_CLEAR, sfwp_pkg::CMD_BLOCK_CLEAR,
		sfwp_pkg::CMD_FULL_CLEAR};
	localparam sfwp_pkg::sfwp_op_type KINDS [3] = '{sfwp_pkg::OPK_SMALL, sfwp_pkg::OPK_BLOCK,
		sfwp_pkg::OPK_FULL};

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("standby", 32'h1, 32'(standby));
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h010000, 32'h0), 48, 99, 2);
		vcc_ok <= 1'b1;
		repeat (40) @(posedge clk);
		u_host.cpol = 1'b1;
		op(hdr(sfwp_pkg::CMD_DISARM_WRITE, 24'h0, 32'h0), 8, 99, 0);
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h010000, 32'h0), 48, 99, 2);
		arm();
		rd_status(8'h02);
		u_host.cpol = 1'b0;
		// Consumer holds off so the accepted bytes can be inspected
		ready <= 1'b0;
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h010010, 32'ha55a0000), 48, 99, 1);
		chk("kind", 32'(sfwp_pkg::OPK_PROG), 32'(op_kind));
		chk("addr", 32'h010010, 32'(op_addr));
		chk("count", 32'h2, 32'(op_count));
		chk("busy status", 32'h01, 32'(status));
		chk("active", 32'h0, 32'(standby));
		pop(8'ha5);
		pop(8'h5a);
		wait_idle();
		chk("standby", 32'h1, 32'(standby));
		arm();
		op(hdr(sfwp_pkg::CMD_DUAL_PROG, 24'h020000, 32'hc33c0000), 40, 32, 1);
		chk("dual count", 32'h2, 32'(op_count));
		pop(8'hc3);
		pop(8'h3c);
		ready <= 1'b1;
		wait_idle();
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h030000, 32'h0), 52, 99, 2);
		for (int e = 0; e < 3; e++) begin
			arm();
			op(hdr(ERASES[e], 24'h041000, 32'h0), (e == 2) ? 8 : 32, 99, 1);
			chk("erase kind", 32'(KINDS[e]), 32'(op_kind));
			wait_idle();
		end
		arm();
		op(hdr(sfwp_pkg::CMD_WRITE_STATUS, 24'h040000, 32'h0), 16, 99, 1);
		wait_idle();
		rd_status(8'h04);
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h0f0000, 32'h0), 48, 99, 2);
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h0e0000, 32'h0), 48, 99, 1);
		wait_idle();
		// Same size code counted from the bottom of the array
		arm();
		op(hdr(sfwp_pkg::CMD_WRITE_STATUS, 24'h240000, 32'h0), 16, 99, 1);
		wait_idle();
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h000000, 32'h0), 48, 99, 2);
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h0f0000, 32'h0), 48, 99, 1);
		wait_idle();
		arm();
		op(hdr(sfwp_pkg::CMD_FULL_CLEAR, 24'h0, 32'h0), 8, 99, 2);
		wp_n <= 1'b0;
		op(hdr(sfwp_pkg::CMD_WRITE_STATUS, 24'h0, 32'h0), 16, 99, 2);
		rd_status(8'h26);
		wp_n <= 1'b1;
		op(hdr(sfwp_pkg::CMD_WRITE_STATUS, 24'h0, 32'h0), 16, 99, 1);
		wait_idle();
		arm();
		op(hdr(sfwp_pkg::CMD_SECTOR_GUARD_WRITE, 24'h050000, 32'h01000000), 40, 99, 3);
		rd_guard(8'h01);
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h050000, 32'h0), 48, 99, 2);
		op(hdr(sfwp_pkg::CMD_SECTOR_GUARD_WRITE, 24'h050000, 32'h03000000), 40, 99, 3);
		arm();
		op(hdr(sfwp_pkg::CMD_SECTOR_GUARD_WRITE, 24'h050000, 32'h0), 40, 99, 3);
		rd_guard(8'h03);
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h050000, 32'h0), 48, 99, 2);
		op(hdr(sfwp_pkg::CMD_SLEEP, 24'h0, 32'h0), 8, 99, 0);
		chk("deep", 32'h1, 32'(deep));
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h060000, 32'h0), 48, 99, 3);
		op(hdr(sfwp_pkg::CMD_WAKE, 24'h0, 32'h0), 8, 99, 0);
		chk("awake", 32'h0, 32'(deep));
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h060000, 32'h0), 48, 99, 1);
		wait_idle();
		ready <= 1'b0;
		arm();
		op(hdr(sfwp_pkg::CMD_PAGE_PROG, 24'h070000, 32'h0), 104, 99, 2);
		ready <= 1'b1;
		repeat (12) @(posedge clk);
		#1;
		chk("fifo drained", 32'h0, 32'(pvalid));
		report_and_stop();
	end
endmodule : tb_sfwp
